// >>> rtl/sdt_timing.sv
/*
  DRAM-side command timing: internal write start, power-down entry,
  preamble mode bits, and an apb register file with a clock rounding
  converter.
  assumes the command pins are driven on the rising edge of link_ck and
  that the apb master follows the usual setup/access protocol.
*/
// Design decisions made here: register access over APB and the register addresses.
`timescale 1ns/1ps
`default_nettype none

// Summary of operation
// - internal write starts write latency plus 4 clocks after write, plus 2 if chop fixed
// - clock enable low mid operation; power-down applies once those operations finish
// - mode register four bit 11 picks one or two clock read preamble, two only with the fast grade strap set
// - mode register four bit 12 picks one or two clock write preamble, two only with the fast grade strap set
// - device accepts clock counts from time over average period, rounded up
module sdt_timing
  import sdt_pkg::*;
(
  // apb clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // apb slave
  input  wire logic [7:0]  paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // link clock and command pins
  input  wire logic        link_ck,
  input  wire logic        cke,
  input  wire logic [2:0]  cmd_code,
  input  wire logic [2:0]  cmd_mr_sel,
  input  wire logic [13:0] cmd_addr,
  input  wire logic        speed_grade_high,
  // link-side results
  output logic             wr_start,
  output logic             power_down,
  output logic             rd_preamble_two,
  output logic             wr_preamble_two
);

  // link reset, released on the link clock
  logic             link_rst_meta;
  logic             link_rst_n;
  // pin pipeline, two flops per input
  logic [20:0]      pin_meta;
  logic [20:0]      pin_sync;
  logic             grade_meta;
  logic             grade_sync;
  // link state
  logic             bc4_fixed;
  logic [4:0]       write_latency;
  logic             mr4_rd_two;
  logic             mr4_wr_two;
  logic [5:0]       wr_cnt;
  logic [7:0]       busy_cnt;
  logic             wr_toggle;
  // apb side state
  logic [SDT_ST_WIDTH-1:0] st_meta;
  logic [SDT_ST_WIDTH-1:0] st_sync;
  logic [2:0]       tog_sync;
  logic [15:0]      wr_count;
  logic [23:0]      conv_param;
  logic [15:0]      conv_tck;

  sdt_cmd_t    cmd_now;
  logic        cke_now;
  logic [2:0]  mr_now;
  logic [13:0] addr_now;
  logic        is_wr;
  logic        is_mrs;
  logic [5:0]  next_wr_cnt;
  logic [5:0]  wr_load;

  sdt_round_if rnd_if ();

  // reset release is synchronous to the link clock; assert stays asynchronous
  always_ff @(posedge link_ck or negedge presetn) begin
    if (!presetn) begin
      link_rst_meta <= 1'b0;
      link_rst_n    <= 1'b0;
    end else begin
      link_rst_meta <= 1'b1;
      link_rst_n    <= link_rst_meta;
    end
  end

  // command pins pass two flops before decode
  always_ff @(posedge link_ck or negedge link_rst_n) begin
    if (!link_rst_n) begin
      pin_meta   <= SDT_PIN_IDLE;
      pin_sync   <= SDT_PIN_IDLE;
      grade_meta <= 1'b0;
      grade_sync <= 1'b0;
    end else begin
      pin_meta   <= {cke, cmd_code, cmd_mr_sel, cmd_addr};
      pin_sync   <= pin_meta;
      grade_meta <= speed_grade_high;
      grade_sync <= grade_meta;
    end
  end

  assign cke_now  = pin_sync[20];
  assign cmd_now  = sdt_cmd_t'(pin_sync[19:17]);
  assign mr_now   = pin_sync[16:14];
  assign addr_now = pin_sync[13:0];
  assign is_wr    = cmd_now == SDT_CMD_WR;
  assign is_mrs   = cmd_now == SDT_CMD_MRS;

  // mode register fields that steer this block
  always_ff @(posedge link_ck or negedge link_rst_n) begin
    if (!link_rst_n) begin
      bc4_fixed     <= 1'b0;
      write_latency <= SDT_WL_RESET;
      mr4_rd_two    <= 1'b0;
      mr4_wr_two    <= 1'b0;
    end else if (is_mrs) begin
      if (mr_now == SDT_MR_ZERO) begin
        bc4_fixed <= addr_now[SDT_MR0_BL_LSB +: 2] == SDT_MR0_BL_BC4FIX;
      end
      if (mr_now == SDT_MR_TWO) begin
        write_latency <= addr_now[SDT_MR2_WL_LSB +: 5];
      end
      if (mr_now == SDT_MR_FOUR) begin
        mr4_rd_two <= addr_now[SDT_MR4_RDPRE_BIT];
        mr4_wr_two <= addr_now[SDT_MR4_WRPRE_BIT];
      end
    end
  end

  // two-clock preambles only hold when the fast grade strap is set
  always_ff @(posedge link_ck or negedge link_rst_n) begin
    if (!link_rst_n) begin
      rd_preamble_two <= 1'b0;
      wr_preamble_two <= 1'b0;
    end else begin
      rd_preamble_two <= mr4_rd_two & grade_sync;
      wr_preamble_two <= mr4_wr_two & grade_sync;
    end
  end

  // delay from the decoded write, less the pin stages, never below one
  always_comb begin
    wr_load = {1'b0, write_latency}
            + (bc4_fixed ? SDT_WR_START_BC4F : SDT_WR_START_BL8)
            - SDT_PIN_STAGES;
    if (wr_load == 6'h0) begin
      wr_load = 6'h1;
    end
    next_wr_cnt = (wr_cnt != 6'h0) ? wr_cnt - 6'h1 : 6'h0;
    if (is_wr) begin
      next_wr_cnt = wr_load;
    end
  end

  // a new write restarts the timer; writes closer than the delay collapse
  always_ff @(posedge link_ck or negedge link_rst_n) begin
    if (!link_rst_n) begin
      wr_cnt    <= 6'h0;
      wr_start  <= 1'b0;
      wr_toggle <= 1'b0;
    end else begin
      wr_cnt   <= next_wr_cnt;
      wr_start <= (wr_cnt == 6'h1) && !is_wr;
      if ((wr_cnt == 6'h1) && !is_wr) begin
        wr_toggle <= ~wr_toggle;
      end
    end
  end

  // row, precharge and refresh work keeps running after cke falls
  always_ff @(posedge link_ck or negedge link_rst_n) begin
    if (!link_rst_n) begin
      busy_cnt <= 8'h0;
    end else if (cmd_now == SDT_CMD_REF) begin
      busy_cnt <= SDT_REF_BUSY_CYC;
    end else if (cmd_now == SDT_CMD_ACT || cmd_now == SDT_CMD_PRE) begin
      busy_cnt <= (busy_cnt > SDT_ROW_BUSY_CYC) ? busy_cnt - 8'h1 : SDT_ROW_BUSY_CYC;
    end else if (busy_cnt != 8'h0) begin
      busy_cnt <= busy_cnt - 8'h1;
    end
  end

  // power-down only applies once internal work has drained
  always_ff @(posedge link_ck or negedge link_rst_n) begin
    if (!link_rst_n) begin
      power_down <= 1'b0;
    end else begin
      power_down <= !cke_now && (busy_cnt == 8'h0);
    end
  end

  // status levels into the apb domain
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_meta <= '0;
      st_sync <= '0;
    end else begin
      st_meta <= {bc4_fixed, wr_preamble_two, rd_preamble_two,
                  busy_cnt != 8'h0, power_down};
      st_sync <= st_meta;
    end
  end

  // write starts cross as a toggle; third stage feeds the edge detect
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tog_sync <= 3'h0;
      wr_count <= 16'h0;
    end else begin
      tog_sync <= {tog_sync[1:0], wr_toggle};
      if (tog_sync[2] != tog_sync[1]) begin
        wr_count <= wr_count + 16'h1;
      end
    end
  end

  // apb: one wait-free access phase, answer registered in setup
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0;
    end else begin
      pready  <= psel && !penable;
      pslverr <= 1'b0;
      if (psel && !penable) begin
        unique case (paddr)
          SDT_STATUS_OFS:  prdata <= {27'h0, st_sync};
          SDT_WRCOUNT_OFS: prdata <= {16'h0, wr_count};
          SDT_CONVPAR_OFS: prdata <= {8'h0, conv_param};
          SDT_CONVTCK_OFS: prdata <= {16'h0, conv_tck};
          SDT_CONVNCK_OFS: prdata <= {16'h0, rnd_if.clock_cycle_count};
          default: begin
            prdata  <= 32'h0;
            pslverr <= 1'b1; // unmapped address
          end
        endcase
      end
    end
  end

  // converter operand registers; writes land on the completing edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      conv_param <= SDT_CONVPAR_RESET;
      conv_tck   <= SDT_CONVTCK_RESET;
    end else if (psel && penable && pready && pwrite) begin
      if (paddr == SDT_CONVPAR_OFS) begin
        conv_param <= pwdata[23:0];
      end
      if (paddr == SDT_CONVTCK_OFS) begin
        conv_tck <= pwdata[15:0];
      end
    end
  end

  assign rnd_if.param_ps = conv_param;
  assign rnd_if.tck_ps   = conv_tck;

  sdt_round u_round (
    .pclk    (pclk),
    .presetn (presetn),
    .rnd     (rnd_if.rounder)
  );

  // checking helpers: age of the last write and its expected wait
  logic [5:0] since_wr;
  logic [5:0] exp_wait;
  always_ff @(posedge link_ck or negedge link_rst_n) begin
    if (!link_rst_n) begin
      since_wr <= 6'h0;
      exp_wait <= 6'h0;
    end else if (is_wr) begin
      since_wr <= 6'h1;
      exp_wait <= {1'b0, write_latency} - SDT_PIN_STAGES
                + (bc4_fixed ? SDT_WR_START_BC4F : SDT_WR_START_BL8);
    end else if (since_wr != 6'h3f) begin
      since_wr <= since_wr + 6'h1;
    end
  end

  property p_wr_start_time;
    @(posedge link_ck) disable iff (!link_rst_n)
    wr_start |-> (since_wr == exp_wait + 6'h1);
  endproperty
  a_wr_start_time: assert property (p_wr_start_time)
    else $error("internal write start at wrong clock");

  property p_pd_held_off;
    @(posedge link_ck) disable iff (!link_rst_n)
    (!cke_now && busy_cnt != 8'h0) |=> !power_down;
  endproperty
  a_pd_held_off: assert property (p_pd_held_off)
    else $error("power-down applied while busy");

  property p_pd_enter;
    @(posedge link_ck) disable iff (!link_rst_n)
    (!cke_now && busy_cnt == 8'h0) |=> power_down;
  endproperty
  a_pd_enter: assert property (p_pd_enter)
    else $error("power-down not applied when idle");

  sequence s_mr4_rd_set;
    is_mrs && mr_now == SDT_MR_FOUR && addr_now[SDT_MR4_RDPRE_BIT] && grade_sync;
  endsequence
  sequence s_mr4_wr_set;
    is_mrs && mr_now == SDT_MR_FOUR && addr_now[SDT_MR4_WRPRE_BIT] && grade_sync;
  endsequence

  property p_rd_pre_set;
    @(posedge link_ck) disable iff (!link_rst_n)
    s_mr4_rd_set ##1 (grade_sync && !is_mrs) |=> rd_preamble_two;
  endproperty
  a_rd_pre_set: assert property (p_rd_pre_set)
    else $error("read preamble not two clocks");

  property p_wr_pre_set;
    @(posedge link_ck) disable iff (!link_rst_n)
    s_mr4_wr_set ##1 (grade_sync && !is_mrs) |=> wr_preamble_two;
  endproperty
  a_wr_pre_set: assert property (p_wr_pre_set)
    else $error("write preamble not two clocks");

  property p_pre_grade;
    @(posedge link_ck) disable iff (!link_rst_n)
    !grade_sync |=> (!rd_preamble_two && !wr_preamble_two);
  endproperty
  a_pre_grade: assert property (p_pre_grade)
    else $error("two-clock preamble at slow grade");

endmodule : sdt_timing
`default_nettype wire

// >>> pkg/sdt_pkg.sv
/*
  constants shared by the DRAM timing block: register map, field positions,
  reset values, command codes and timing figures.
  assumes nothing beyond a SystemVerilog compiler.
*/
package sdt_pkg;

  // apb register byte offsets
  localparam logic [7:0] SDT_STATUS_OFS   = 8'h00;
  localparam logic [7:0] SDT_WRCOUNT_OFS  = 8'h04;
  localparam logic [7:0] SDT_CONVPAR_OFS  = 8'h08;
  localparam logic [7:0] SDT_CONVTCK_OFS  = 8'h0c;
  localparam logic [7:0] SDT_CONVNCK_OFS  = 8'h10;

  // status register fields
  localparam int SDT_ST_PD_BIT     = 0;
  localparam int SDT_ST_BUSY_BIT   = 1;
  localparam int SDT_ST_RDPRE_BIT  = 2;
  localparam int SDT_ST_WRPRE_BIT  = 3;
  localparam int SDT_ST_BC4_BIT    = 4;
  localparam int SDT_ST_WIDTH      = 5;

  // mode register fields carried on the command address pins
  localparam logic [2:0] SDT_MR_ZERO  = 3'h0;
  localparam logic [2:0] SDT_MR_TWO   = 3'h2;
  localparam logic [2:0] SDT_MR_FOUR  = 3'h4;
  localparam int         SDT_MR0_BL_LSB    = 0;
  localparam logic [1:0] SDT_MR0_BL_BC4FIX = 2'h2;
  localparam int         SDT_MR2_WL_LSB    = 0;
  localparam int         SDT_MR4_RDPRE_BIT = 11;
  localparam int         SDT_MR4_WRPRE_BIT = 12;

  // command codes on the link
  typedef enum logic [2:0] {
    SDT_CMD_NOP = 3'h0,
    SDT_CMD_MRS = 3'h1,
    SDT_CMD_ACT = 3'h2,
    SDT_CMD_PRE = 3'h3,
    SDT_CMD_REF = 3'h4,
    SDT_CMD_WR  = 3'h5,
    SDT_CMD_RD  = 3'h6
  } sdt_cmd_t;

  // write start offsets after write latency, in link clocks
  localparam logic [5:0] SDT_WR_START_BL8  = 6'h04;
  localparam logic [5:0] SDT_WR_START_BC4F = 6'h02;
  localparam logic [5:0] SDT_PIN_STAGES    = 6'h02;
  localparam logic [4:0] SDT_WL_RESET      = 5'h09;
  // pin pipeline reset: cke high and a nop, so no false power-down follows reset
  localparam logic [20:0] SDT_PIN_IDLE     = 21'h10_0000;

  // internal operation durations, in link clocks
  localparam logic [7:0] SDT_ROW_BUSY_CYC = 8'h04;
  localparam logic [7:0] SDT_REF_BUSY_CYC = 8'h10;

  // refresh cycle minima in ns; the normal one is the converter default
  localparam int SDT_RFC_NORMAL_NS = 350;
  localparam int SDT_RFC_DOUBLE_NS = 260;
  localparam int SDT_RFC_QUAD_NS   = 160;
  localparam int SDT_PS_PER_NS     = 1000;

  // rounding converter figures
  localparam logic [23:0] SDT_CONVPAR_RESET = 24'(SDT_RFC_NORMAL_NS * SDT_PS_PER_NS);
  localparam logic [15:0] SDT_CONVTCK_RESET = 16'h03a9;
  localparam logic [63:0] SDT_RND_SCALE     = 64'h0000_0000_0000_03e8;
  localparam logic [63:0] SDT_RND_CORR      = 64'h0000_0000_0000_03ce;
  localparam logic [63:0] SDT_RND_SLACK     = 64'h0000_0000_0000_0019;

endpackage : sdt_pkg

// >>> pkg/sdt_round_if.sv
/*
  carrier between the register side and the clock rounding converter.
  assumes both ends run on the apb clock.
*/
`timescale 1ns/1ps
`default_nettype none
interface sdt_round_if;
  logic [23:0] param_ps;  // parameter time in ps
  logic [15:0] tck_ps;    // clock period in whole ps
  logic [15:0] clock_cycle_count;       // rounded clock count

  modport requester (output param_ps, output tck_ps, input clock_cycle_count);
  modport rounder (input param_ps, input tck_ps, output clock_cycle_count);
endinterface : sdt_round_if
`default_nettype wire

// >>> rtl/sdt_round.sv
/*
  converts a time in ps into a whole clock count with the 2.5 % correction.
  assumes its inputs are quasi-static register values on pclk.
*/
`timescale 1ns/1ps
`default_nettype none
module sdt_round
  import sdt_pkg::*;
(
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // converter operands and result
  sdt_round_if.rounder     rnd
);

  logic [63:0] next_count;

  // integer form: scale, divide, add inverse correction, truncate
  always_comb begin
    logic [63:0] quot;
    quot = 64'h0;
    next_count = 64'h0;
    if (rnd.tck_ps != 16'h0) begin // a zero period gives a zero count
      quot       = (64'(rnd.param_ps) * SDT_RND_SCALE) / 64'(rnd.tck_ps);
      next_count = (quot + SDT_RND_CORR) / SDT_RND_SCALE;
    end
  end

  // registered so the divider path ends in a flop
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rnd.clock_cycle_count <= 16'h0;
    end else begin
      rnd.clock_cycle_count <= next_count[15:0];
    end
  end

  // count covers the time; the integer form may fall just under 26 thousandths short
  property p_nck_enough;
    @(posedge pclk) disable iff (!presetn)
    (presetn && $stable(rnd.tck_ps) && $stable(rnd.param_ps) && rnd.tck_ps != 16'h0) |=>
      (64'(rnd.clock_cycle_count) * 64'($past(rnd.tck_ps)) * SDT_RND_SCALE
       + (SDT_RND_SLACK + 64'h1) * 64'($past(rnd.tck_ps))
       > 64'($past(rnd.param_ps)) * SDT_RND_SCALE);
  endproperty
  a_nck_enough: assert property (p_nck_enough)
    else $error("rounded count too small");

  // one count fewer would not cover it
  property p_nck_tight;
    @(posedge pclk) disable iff (!presetn)
    ($stable(rnd.tck_ps) && $stable(rnd.param_ps) && rnd.tck_ps != 16'h0) ##1
      (rnd.clock_cycle_count != 16'h0) |->
      (64'(rnd.clock_cycle_count - 16'h1) * 64'($past(rnd.tck_ps)) * SDT_RND_SCALE
       + SDT_RND_SLACK * 64'($past(rnd.tck_ps))
       < 64'($past(rnd.param_ps)) * SDT_RND_SCALE);
  endproperty
  a_nck_tight: assert property (p_nck_tight)
    else $error("rounded count too large");

endmodule : sdt_round
`default_nettype wire

// >>> bench/sdt_ctrl_model.sv
/*
  behavioural memory controller that drives the command pins of the timing block.
  assumes link_ck runs free and that the bench calls one task at a time.
*/
`timescale 1ns/1ps
`default_nettype none
module sdt_ctrl_model
  import sdt_pkg::*;
#(
  parameter int          TCK_PS        = 125000,
  parameter int          LOCK_CYC      = 64,       // delay-loop lock time, plain default
  // recovery at the 1600 grade; a link slower than that keeps these figures
  parameter longint      WR_REC_PS     = 15000,
  parameter longint      WR_REC_CRC_PS = 18000,
  parameter int          GEAR_SETUP    = 2,
  parameter logic [2:0]  GEAR_MR_SEL   = 3'h3,
  parameter logic [13:0] GEAR_MR_DATA  = 14'h0008
)
(
  // link clock
  input  wire logic        link_ck,
  // command pins
  output logic             cke,
  output logic [2:0]       cmd_code,
  output logic [2:0]       cmd_mr_sel,
  output logic [13:0]      cmd_addr
);
  // idle pins at time zero
  initial begin
    cke        = 1'b1;
    cmd_code   = SDT_CMD_NOP;
    cmd_mr_sel = 3'h0;
    cmd_addr   = 14'h0000;
  end

  // delay-loop lock time counted from start; reads wait for it
  int lock_cnt;
  always @(posedge link_ck) begin
    if (lock_cnt < LOCK_CYC) lock_cnt <= lock_cnt + 1;
  end

  // integer rounding of a time in ps into link clocks
  function automatic int to_nck(input longint ps);
    return int'((ps * 1000 / TCK_PS + 974) / 1000);
  endfunction : to_nck

  // plain round-up of a time in ps into link clocks
  function automatic int ceil_nck(input longint ps);
    return int'((ps + TCK_PS - 1) / TCK_PS);
  endfunction : ceil_nck

  // one command for one cycle, then a counted gap before the next one
  task automatic issue(input sdt_cmd_t c, input logic [2:0] sel, input logic [13:0] a);
    int gap;
    while (c == SDT_CMD_RD && lock_cnt < LOCK_CYC) @(posedge link_ck);
    @(posedge link_ck);
    cmd_code   <= c;
    cmd_mr_sel <= sel;
    cmd_addr   <= a;
    @(posedge link_ck);
    cmd_code <= SDT_CMD_NOP;
    cmd_addr <= ~a; // released address pins do not keep the last value
    gap = 1;
    if (c == SDT_CMD_REF) gap = to_nck(SDT_RFC_NORMAL_NS * SDT_PS_PER_NS);
    if (c == SDT_CMD_MRS && sel == 3'h7) gap = 5;
    // down-counter blocks the next command until it runs out
    while (gap > 1) begin
      @(posedge link_ck);
      gap--;
    end
  endtask : issue

  // clock enable level change on a link edge
  task automatic cke_set(input logic v);
    @(posedge link_ck);
    cke <= v;
  endtask : cke_set

  // write, then power-down entry after latency, burst and rounded recovery
  task automatic wr_pd(input int wl, input logic fix4, input logic crc_mask,
                       input logic auto_pre, input int mr0_wr);
    int gap;
    issue(SDT_CMD_WR, 3'h0, 14'h0000);
    gap = wl + (fix4 ? 2 : 4) + ceil_nck(crc_mask ? WR_REC_CRC_PS : WR_REC_PS);
    if (auto_pre) gap = wl + (fix4 ? 2 : 4) + mr0_wr + 1;
    repeat (gap) @(posedge link_ck);
    cke <= 1'b0;
  endtask : wr_pd

  // gear-down entry: mode write, even setup, sync pulse, even hold, first command;
  // this link has no chip select, so the sync pulse rides on cke
  task automatic gear_down();
    int span;
    span = (GEAR_SETUP < 2) ? 2 : GEAR_SETUP + (GEAR_SETUP % 2);
    issue(SDT_CMD_MRS, GEAR_MR_SEL, GEAR_MR_DATA);
    repeat (span) @(posedge link_ck);
    cke <= 1'b0;
    @(posedge link_ck);
    cke <= 1'b1;
    repeat (span) @(posedge link_ck);
    issue(SDT_CMD_ACT, 3'h0, 14'h0000);
  endtask : gear_down
endmodule : sdt_ctrl_model
`default_nettype wire

// >>> bench/sdt_timing_rules_and_clock_rounding_bench.sv
/*
  self-checking bench for the DRAM timing block: apb registers, rounding, write start.
  assumes the controller model drives the pins and apb replies without wait states.
*/
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) begin tests_run++; if ((got) !== (exp)) begin mismatches++; \
  $display("mismatch at %0t: got %0h expected %0h", $time, (got), (exp)); end end
module sdt_timing_rules_and_clock_rounding_bench;
  import sdt_pkg::*;
  logic        pclk, presetn, psel, penable, pwrite, link_ck, speed_grade_high;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rdat;
  logic        pready, pslverr, rerr, wr_start, power_down, rd_pre, wr_pre;
  logic        cke;
  logic [2:0]  cmd_code, cmd_mr_sel;
  logic [13:0] cmd_addr;
  int          mismatches, tests_run, seed, lk_cnt, e0, starts, nwr, n, i, m;
  int          wls[4] = '{9, 12, 20, 0};
  int          exp_q[$];
  longint      par, tck;

  sdt_timing dut (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .link_ck(link_ck), .cke(cke), .cmd_code(cmd_code),
    .cmd_mr_sel(cmd_mr_sel), .cmd_addr(cmd_addr), .speed_grade_high(speed_grade_high),
    .wr_start(wr_start), .power_down(power_down), .rd_preamble_two(rd_pre),
    .wr_preamble_two(wr_pre));
  sdt_ctrl_model ctl (.link_ck(link_ck), .cke(cke), .cmd_code(cmd_code),
    .cmd_mr_sel(cmd_mr_sel), .cmd_addr(cmd_addr));

  // clocks: link clock offset so the two never line up
  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end
  initial begin
    link_ck = 1'b0;
    #17;
    forever #62.5 link_ck = ~link_ck;
  end

  // reference models of both rounding forms
  function automatic longint nck_int(input longint p, input longint t);
    return (t == 0) ? 0 : (p * 1000 / t + 974) / 1000;
  endfunction : nck_int
  function automatic longint nck_real(input real p, input real t);
    return longint'($ceil(p / t - 0.025));
  endfunction : nck_real

  // one apb transfer; request held until pready is seen high
  task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
    int k;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    paddr   <= a;
    pwrite  <= w;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    if (k >= 50) mismatches++;
    rdat = prdata;
    rerr = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // write start timing: pin edge of the write to the edge that sees the pulse
  always @(posedge link_ck) begin
    if (cmd_code === SDT_CMD_WR) e0 = lk_cnt;
    if (wr_start === 1'b1) begin
      starts++;
      if (exp_q.size() == 0) `CHK(1'b1, 1'b0)
      else `CHK(lk_cnt - e0, exp_q.pop_front())
    end
    lk_cnt++;
  end

  task automatic summarize();
    $display("checks %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : summarize

  // watchdog well beyond the expected run length
  initial begin
    #400000;
    mismatches++;
    summarize();
  end

  initial begin
    {psel, penable, pwrite, speed_grade_high} = 4'h0;
    paddr = 8'h00;
    pwdata = 32'h0;
    presetn = 1'b0;
    seed = 32'h0034;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    repeat (4) @(posedge link_ck);
    // reset values, read-only write, unmapped place
    apb(SDT_CONVPAR_OFS, 1'b0, 32'h0);
    `CHK(rdat, {8'h00, SDT_CONVPAR_RESET})
    apb(SDT_CONVTCK_OFS, 1'b0, 32'h0);
    `CHK(rdat, 32'($rtoi(0.9375e3)))
    apb(SDT_CONVNCK_OFS, 1'b0, 32'h0);
    `CHK(rdat, 32'(nck_int(350000, 937)))
    apb(SDT_STATUS_OFS, 1'b1, 32'hffff_ffff);
    apb(SDT_STATUS_OFS, 1'b0, 32'h0);
    `CHK({rerr, rdat}, 33'h0)
    apb(8'h14, 1'b1, 32'h1234_5678);
    `CHK(rerr, 1'b1)
    apb(8'h14, 1'b0, 32'h0);
    `CHK({rerr, rdat}, {1'b1, 32'h0})
    // refresh minima at two truncated periods, then random operands and a zero period
    for (i = 0; i < 13; i++) begin
      par = (i < 6) ? ((i % 3 == 0) ? 350000 : (i % 3 == 1) ? 260000 : 160000)
                    : ($random(seed) & 24'hffffff);
      tck = (i < 3) ? $rtoi(1.0714e3) : (i < 6) ? 937 : (i == 12) ? 0
                    : 500 + ($random(seed) & 16'h7ff);
      apb(SDT_CONVPAR_OFS, 1'b1, 32'(par));
      apb(SDT_CONVTCK_OFS, 1'b1, 32'(tck));
      apb(SDT_STATUS_OFS, 1'b0, 32'h0);
      apb(SDT_CONVNCK_OFS, 1'b0, 32'h0);
      `CHK(rdat, 32'(nck_int(par, tck)))
      if (i < 6) `CHK(rdat, 32'(nck_real(par, tck)))
    end
    // write start for each latency and burst mode
    wls[3] = 8 + ($random(seed) & 15);
    for (i = 0; i < 4; i++) begin
      for (m = 0; m < 3; m++) begin
        ctl.issue(SDT_CMD_MRS, SDT_MR_TWO, 14'(wls[i]));
        ctl.issue(SDT_CMD_MRS, SDT_MR_ZERO, 14'(m));
        exp_q.push_back(wls[i] + ((m == 2) ? 3 : 5));
        nwr++;
        ctl.issue(SDT_CMD_WR, 3'h0, 14'h0000);
        n = 0;
        while (starts < nwr && n < 60) begin
          @(posedge link_ck);
          n++;
        end
        `CHK(starts, nwr)
      end
    end
    ctl.issue(SDT_CMD_MRS, SDT_MR_ZERO, 14'h0000);
    repeat (12) @(posedge pclk);
    apb(SDT_WRCOUNT_OFS, 1'b0, 32'h0);
    `CHK(rdat, 32'(nwr))
    // preamble bits against grade strap
    for (i = 0; i < 8; i++) begin
      @(posedge pclk);
      speed_grade_high <= i[2];
      ctl.issue(SDT_CMD_MRS, SDT_MR_FOUR, 14'(i[1:0]) << 11);
      repeat (6) @(posedge link_ck);
      `CHK(rd_pre, i[0] & i[2])
      `CHK(wr_pre, i[1] & i[2])
      apb(SDT_STATUS_OFS, 1'b0, 32'h0);
      `CHK(rdat[3:2], {i[1] & i[2], i[0] & i[2]})
    end
    // power-down when idle, after a write, after a row command, during a refresh
    ctl.cke_set(1'b0);
    repeat (3) @(posedge link_ck);
    `CHK(power_down, 1'b0)
    @(posedge link_ck);
    `CHK(power_down, 1'b1)
    apb(SDT_STATUS_OFS, 1'b0, 32'h0);
    `CHK(rdat[0], 1'b1)
    ctl.cke_set(1'b1);
    repeat (8) @(posedge link_ck);
    `CHK(power_down, 1'b0)
    ctl.issue(SDT_CMD_RD, 3'h0, 14'h0000);
    exp_q.push_back(wls[3] + 5);
    nwr++;
    ctl.wr_pd(wls[3], 1'b0, 1'b1, 1'b0, 0);
    repeat (4) @(posedge link_ck);
    `CHK(power_down, 1'b1)
    `CHK(starts, nwr)
    ctl.cke_set(1'b1);
    repeat (8) @(posedge link_ck);
    ctl.gear_down();
    repeat (8) @(posedge link_ck);
    `CHK(power_down, 1'b0)
    ctl.issue(SDT_CMD_ACT, 3'h0, 14'h0000);
    ctl.cke_set(1'b0);
    repeat (6) @(posedge link_ck);
    `CHK(power_down, 1'b0)
    @(posedge link_ck);
    `CHK(power_down, 1'b1)
    ctl.cke_set(1'b1);
    repeat (8) @(posedge link_ck);
    ctl.issue(SDT_CMD_REF, 3'h0, 14'h0000);
    ctl.cke_set(1'b0);
    repeat (8) @(posedge link_ck);
    `CHK(power_down, 1'b0)
    n = 0;
    while (power_down !== 1'b1 && n < 24) begin
      @(posedge link_ck);
      n++;
    end
    `CHK(power_down, 1'b1)
    summarize();
  end
endmodule : sdt_timing_rules_and_clock_rounding_bench
`default_nettype wire
